// File: hw/crie_code_if.sv
// Purpose: carries one bus state code between block modules
// Assumes: single clock domain
// Notes:   src drives, dst reads
`timescale 1ns/1ns
`default_nettype none
interface crie_code_if;
    crie_pkg::crie_code_t code;
    modport src (output code);
    modport dst (input code);
endinterface : crie_code_if
`default_nettype wire

// File: hw/crie_err_encode.sv
// Purpose: turns an error counter into a bus state code
// Assumes: counter value is already synchronous to aclk
// Notes:   forcing inputs override the counter
`timescale 1ns/1ns
`default_nettype none
module crie_err_encode #(
    parameter int CNT_W = crie_pkg::RX_CNT_W
) (
    input  wire logic [CNT_W-1:0] err_count,
    input  wire logic             force_busoff,
    input  wire logic             force_normal,
    crie_code_if.src              out_if
);
    import crie_pkg::*;

    // threshold ladder, forcing first
    always_comb begin
        if (force_busoff) begin
            out_if.code = CODE_BUSOFF;
        end else if (force_normal) begin
            out_if.code = CODE_OK;
        end else if (int'(err_count) > BUSOFF_LIMIT) begin
            out_if.code = CODE_BUSOFF;
        end else if (int'(err_count) > PASSIVE_LIMIT) begin
            out_if.code = CODE_PASSIVE;
        end else if (int'(err_count) > WARN_LIMIT) begin
            out_if.code = CODE_WARN;
        end else begin
            out_if.code = CODE_OK;
        end
    end
endmodule : crie_err_encode
`default_nettype wire

// File: hw/crie_pkg.sv
// Purpose: shared constants of the receive interrupt enable block
// Assumes: 32-bit AXI4-Lite register access, byte-lane 0 carries the 8-bit registers
// Notes:   enable and flag registers share one bit layout
package crie_pkg;
    // register map
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 32;
    localparam int          REG_W        = 8;
    localparam logic [3:0]  OFS_ENABLE   = 4'h0;
    localparam logic [3:0]  OFS_FLAGS    = 4'h4;
    // bit layout shared by enable and flag registers
    localparam int          BIT_WAKEUP   = 7;
    localparam int          BIT_CSC      = 6;
    localparam int          RSENS_LO     = 4;
    localparam int          TSENS_LO     = 2;
    localparam int          SENS_W       = 2;
    localparam int          BIT_OVR      = 1;
    localparam int          BIT_RXF      = 0;
    localparam logic [7:0]  ENABLE_RESET = 8'h00;
    localparam logic [7:0]  SENS_MASK    = 8'h3C;
    localparam logic [7:0]  EVENT_MASK   = 8'hC3;
    // bus state codes
    typedef logic [1:0] crie_code_t;
    localparam crie_code_t  CODE_OK      = 2'h0;
    localparam crie_code_t  CODE_WARN    = 2'h1;
    localparam crie_code_t  CODE_PASSIVE = 2'h2;
    localparam crie_code_t  CODE_BUSOFF  = 2'h3;
    // sensitivity selections
    localparam crie_code_t  SENS_NONE    = 2'h0;
    localparam crie_code_t  SENS_BUSOFF  = 2'h1;
    localparam crie_code_t  SENS_PASSIVE = 2'h2;
    localparam crie_code_t  SENS_ALL     = 2'h3;
    // error counter thresholds
    localparam int          WARN_LIMIT   = 96;
    localparam int          PASSIVE_LIMIT = 127;
    localparam int          BUSOFF_LIMIT = 255;
    localparam int          RX_CNT_W     = 8;
    localparam int          TX_CNT_W     = 9;
    // bus responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : crie_pkg

// File: hw/crie_sens_detect.sv
// Purpose: decides whether a state code change counts as a status change
// Assumes: old is the reported code, new the actual code
// Notes:   no change never hits
`timescale 1ns/1ns
`default_nettype none
module crie_sens_detect (
    crie_code_if.dst              old_if,
    crie_code_if.dst              new_if,
    input  wire logic [1:0]       sens,
    output logic                  hit
);
    import crie_pkg::*;

    logic changed;
    assign changed = (old_if.code != new_if.code);

    // filter change by selected sensitivity
    always_comb begin
        unique case (sens)
            SENS_NONE:    hit = 1'b0;
            SENS_BUSOFF:  hit = changed && (old_if.code == CODE_BUSOFF || new_if.code == CODE_BUSOFF);
            SENS_PASSIVE: hit = changed && (old_if.code[1] || new_if.code[1]);
            SENS_ALL:     hit = changed;
        endcase
    end
endmodule : crie_sens_detect
`default_nettype wire

// File: hw/crie_top.sv
// Purpose: receive interrupt enable register with flags, state codes and request lines
// Assumes: events are one-cycle pulses synchronous to aclk; error counts are live values
// Notes:   enable register doubles as the interrupt mask of the flag register
//
// Behaviour
// - Event enable bits clear and stay clear while init request and acknowledge are high.
// - Enable register readable always, writable only when init request and acknowledge low.
// - Sensitivity fields keep their value through initialization mode.
// - Wake-up enable set: wake-up event raises wake-up request; clear: none.
// - Status-change enable set: status change raises error request; clear: none.
// - Receiver sensitivity picks which receiver changes set the status-change flag.
// - Transmitter sensitivity picks which transmitter changes set the status-change flag.
// - Reported state codes follow actual state, updated only while no status-change flag pending.
// - Overrun enable set: overrun event raises error request; clear: none.
// - Receive-full enable set: full foreground buffer raises receiver request.
// - Cleared enable blocks the request while the event flag still sets.
// - Receiver has bus-off code; transmitter leaving bus-off forces receiver to normal.
// - Receiver code 00 for count up to 96, 01 above 96 up to 127.
// - Bus-off only when transmit count exceeds 255; it forces receiver bus-off too.
// - Pending status-change flag freezes reported codes until software clears it.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module crie_top (
    input  wire logic                          aclk,
    input  wire logic                          aclk_en,
    input  wire logic                          aresetn,
    // axi4-lite slave
    input  wire logic [crie_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [crie_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [crie_pkg::DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [crie_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [crie_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // controller side
    input  wire logic                          init_request,
    input  wire logic                          init_acknowledge,
    input  wire logic [crie_pkg::RX_CNT_W-1:0] rx_err_count,
    input  wire logic [crie_pkg::TX_CNT_W-1:0] tx_err_count,
    input  wire logic                          wakeup_event,
    input  wire logic                          overrun_event,
    input  wire logic                          rx_full_event,
    // request lines
    output logic                               irq_wakeup,
    output logic                               irq_error,
    output logic                               irq_receive,
    output logic                               irq
);
    import crie_pkg::*;

    logic [REG_W-1:0]  enable_ff;
    logic              wakeup_flag_ff;
    logic              csc_flag_ff;
    logic              ovr_flag_ff;
    logic              rxf_flag_ff;
    crie_code_t        rx_code_ff;
    crie_code_t        tx_code_ff;
    logic              tx_was_busoff_ff;
    logic              aw_got_ff;
    logic              w_got_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [REG_W-1:0]  wdata_ff;
    logic              wstrb_ff;
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0]        rresp_ff;
    logic              irq_wakeup_ff;
    logic              irq_error_ff;
    logic              irq_receive_ff;
    logic              irq_ff;
    logic              init_mode;
    logic              write_allowed;
    logic              do_write;
    logic              wr_enable;
    logic              wr_flags;
    logic              rx_hit;
    logic              tx_hit;
    logic              csc_set;
    logic              tx_leaves_busoff;
    logic [REG_W-1:0]  flags_view;

    crie_code_if rx_act_if ();
    crie_code_if tx_act_if ();
    crie_code_if rx_rep_if ();
    crie_code_if tx_rep_if ();

    // mode decode
    assign init_mode     = init_request && init_acknowledge;
    assign write_allowed = !init_request && !init_acknowledge;

    // actual state codes from error counters
    assign tx_leaves_busoff = tx_was_busoff_ff && (tx_act_if.code != CODE_BUSOFF);

    crie_err_encode #(.CNT_W(TX_CNT_W)) u_tx_encode (
        .err_count    (tx_err_count),
        .force_busoff (1'b0),
        .force_normal (1'b0),
        .out_if       (tx_act_if)
    );

    crie_err_encode #(.CNT_W(RX_CNT_W)) u_rx_encode (
        .err_count    (rx_err_count),
        .force_busoff (tx_act_if.code == CODE_BUSOFF),
        .force_normal (tx_leaves_busoff),
        .out_if       (rx_act_if)
    );

    // reported codes into the change filters
    assign rx_rep_if.code = rx_code_ff;
    assign tx_rep_if.code = tx_code_ff;

    crie_sens_detect u_rx_sens (
        .old_if (rx_rep_if),
        .new_if (rx_act_if),
        .sens   (enable_ff[RSENS_LO +: SENS_W]),
        .hit    (rx_hit)
    );

    crie_sens_detect u_tx_sens (
        .old_if (tx_rep_if),
        .new_if (tx_act_if),
        .sens   (enable_ff[TSENS_LO +: SENS_W]),
        .hit    (tx_hit)
    );

    // bus-off history for the receiver recovery
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_was_busoff_ff <= 1'b0;
        end else if (aclk_en) begin
            tx_was_busoff_ff <= (tx_act_if.code == CODE_BUSOFF);
        end
    end

    // write strobes
    assign do_write  = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_enable = do_write && wstrb_ff && (awaddr_ff == OFS_ENABLE);
    assign wr_flags  = do_write && wstrb_ff && (awaddr_ff == OFS_FLAGS);

    // enable register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_ff <= ENABLE_RESET;
        end else if (aclk_en) begin
            if (init_mode) begin
                enable_ff <= (enable_ff & SENS_MASK) | (ENABLE_RESET & EVENT_MASK);
            end else if (wr_enable && write_allowed) begin
                enable_ff <= wdata_ff;
            end
        end
    end

    // reported state codes, frozen while a status change is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_code_ff <= CODE_OK;
            tx_code_ff <= CODE_OK;
        end else if (aclk_en && !csc_flag_ff) begin
            rx_code_ff <= rx_act_if.code;
            tx_code_ff <= tx_act_if.code;
        end
    end

    // sticky event flags, set beats write-one-clear except on the status-change flag
    assign csc_set = !csc_flag_ff && (rx_hit || tx_hit);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wakeup_flag_ff <= 1'b0;
            csc_flag_ff    <= 1'b0;
            ovr_flag_ff    <= 1'b0;
            rxf_flag_ff    <= 1'b0;
        end else if (aclk_en) begin
            wakeup_flag_ff <= wakeup_event  || (wakeup_flag_ff && !(wr_flags && wdata_ff[BIT_WAKEUP]));
            csc_flag_ff    <= csc_set       || (csc_flag_ff && !(wr_flags && wdata_ff[BIT_CSC]));
            ovr_flag_ff    <= overrun_event || (ovr_flag_ff && !(wr_flags && wdata_ff[BIT_OVR]));
            rxf_flag_ff    <= rx_full_event || (rxf_flag_ff && !(wr_flags && wdata_ff[BIT_RXF]));
        end
    end

    // request lines, flag gated by enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_wakeup_ff  <= 1'b0;
            irq_error_ff   <= 1'b0;
            irq_receive_ff <= 1'b0;
            irq_ff         <= 1'b0;
        end else if (aclk_en) begin
            irq_wakeup_ff  <= wakeup_flag_ff && enable_ff[BIT_WAKEUP];
            irq_error_ff   <= (csc_flag_ff && enable_ff[BIT_CSC])
                              || (ovr_flag_ff && enable_ff[BIT_OVR]);
            irq_receive_ff <= rxf_flag_ff && enable_ff[BIT_RXF];
            irq_ff         <= |(flags_view & enable_ff & EVENT_MASK);
        end
    end

    // flag register view
    assign flags_view = {wakeup_flag_ff, csc_flag_ff, rx_code_ff, tx_code_ff, ovr_flag_ff, rxf_flag_ff};

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= 1'b0;
        end else if (aclk_en) begin
            if (s_axi_awvalid && awready_ff) begin
                aw_got_ff  <= 1'b1;
                awready_ff <= 1'b0;
                awaddr_ff  <= s_axi_awaddr;
            end else if (bvalid_ff && s_axi_bready) begin
                aw_got_ff  <= 1'b0;
                awready_ff <= 1'b1;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_got_ff  <= 1'b1;
                wready_ff <= 1'b0;
                wdata_ff  <= s_axi_wdata[REG_W-1:0];
                wstrb_ff  <= s_axi_wstrb[0];
            end else if (bvalid_ff && s_axi_bready) begin
                w_got_ff  <= 1'b0;
                wready_ff <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (aclk_en) begin
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (awaddr_ff == OFS_ENABLE || awaddr_ff == OFS_FLAGS) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel, answers at the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end else if (aclk_en) begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                if (s_axi_araddr == OFS_ENABLE) begin
                    rdata_ff <= {{(DATA_W-REG_W){1'b0}}, enable_ff};
                    rresp_ff <= RESP_OKAY;
                end else if (s_axi_araddr == OFS_FLAGS) begin
                    rdata_ff <= {{(DATA_W-REG_W){1'b0}}, flags_view};
                    rresp_ff <= RESP_OKAY;
                end else begin
                    rdata_ff <= '0;
                    rresp_ff <= RESP_SLVERR;
                end
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // output drive
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign irq_wakeup    = irq_wakeup_ff;
    assign irq_error     = irq_error_ff;
    assign irq_receive   = irq_receive_ff;
    assign irq           = irq_ff;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_init_clears_enables: assert property (aclk_en && init_mode
        |=> (enable_ff & EVENT_MASK) == ENABLE_RESET)
        else $error("event enables not cleared in init mode");
    a_init_keeps_sens: assert property (aclk_en && init_mode
        |=> (enable_ff & SENS_MASK) == ($past(enable_ff) & SENS_MASK))
        else $error("sensitivity changed by init mode");
    a_no_write_half_init: assert property (aclk_en && (init_request ^ init_acknowledge) |=> $stable(enable_ff))
        else $error("enable register changed outside write window");
    a_write_lands: assert property (aclk_en && wr_enable && write_allowed |=> enable_ff == $past(wdata_ff))
        else $error("allowed write did not land");
    a_wakeup_request: assert property (aclk_en && wakeup_flag_ff && enable_ff[BIT_WAKEUP]
        |=> irq_wakeup_ff && irq_ff)
        else $error("wake-up request missing");
    a_error_from_csc: assert property (aclk_en && csc_flag_ff && enable_ff[BIT_CSC] |=> irq_error_ff)
        else $error("status change request missing");
    a_error_from_ovr: assert property (aclk_en && ovr_flag_ff && enable_ff[BIT_OVR] |=> irq_error_ff)
        else $error("overrun request missing");
    a_receive_request: assert property (aclk_en && rx_full_event
        |=> ##1 (irq_receive_ff == $past(enable_ff[BIT_RXF])))
        else $error("receive request wrong");
    a_masked_silent: assert property (aclk_en && !enable_ff[BIT_RXF] && !enable_ff[BIT_WAKEUP]
        |=> !irq_receive_ff && !irq_wakeup_ff)
        else $error("masked event raised a request");
    a_codes_frozen: assert property (aclk_en && csc_flag_ff
        |=> $stable(rx_code_ff) && $stable(tx_code_ff))
        else $error("codes moved while status change pending");
    a_codes_follow: assert property (aclk_en && !csc_flag_ff |=> tx_code_ff == $past(tx_act_if.code))
        else $error("reported code not updated");
    a_sens_none_quiet: assert property (aclk_en && !csc_flag_ff
        && !(|(enable_ff & SENS_MASK)) |=> !csc_flag_ff)
        else $error("status change set with no sensitivity");
    a_busoff_rx_code: assert property (int'(tx_err_count) > BUSOFF_LIMIT
        |-> rx_act_if.code == CODE_BUSOFF && tx_act_if.code == CODE_BUSOFF)
        else $error("bus-off not reported");
    a_rx_warn_band: assert property (int'(tx_err_count) <= BUSOFF_LIMIT && !tx_leaves_busoff
        && int'(rx_err_count) > WARN_LIMIT && int'(rx_err_count) <= PASSIVE_LIMIT |-> rx_act_if.code == CODE_WARN)
        else $error("receiver warning code wrong");
    a_recover_rx_ok: assert property (tx_leaves_busoff |-> rx_act_if.code == CODE_OK)
        else $error("receiver not forced normal on bus-off exit");

    c_init_mode: cover property (aclk_en && init_mode ##1 !init_mode);
    c_csc_irq: cover property (aclk_en && csc_set ##[1:3] irq_error_ff);
    c_busoff_exit: cover property (tx_leaves_busoff);
    c_write_done: cover property (do_write ##1 bvalid_ff);
endmodule : crie_top
`default_nettype wire

// File: verification/crie_top_tb.sv
// Purpose: self-checking bench of the receive interrupt enable block
// Assumes: bench acts as AXI4-Lite master; aclk_en and wstrb tied on
// Notes:   expectations come from the bench's own bit table and state codes
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module crie_top_tb;
    import crie_pkg::*;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr  = 4'h0;
    logic [3:0]  araddr  = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b1;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b1;
    logic [31:0] wdata   = 32'h0;
    logic        init_rq = 1'b0;
    logic        init_ak = 1'b0;
    logic [7:0]  rx_cnt  = 8'h00;
    logic [8:0]  tx_cnt  = 9'h000;
    logic [2:0]  ev      = 3'h0;
    logic [31:0] seed    = 32'h3CBF;
    logic [31:0] rd_q;
    logic [31:0] v;
    logic [1:0]  rsp_q;
    wire         awready, wready, bvalid, arready, rvalid, irq_w, irq_e, irq_r, irq_any;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          err_total = 0;
    int          total_checks = 0;
    int          m_en = 0;
    int          cyc = 0;
    int          fbit[3] = '{7, 1, 0};
    crie_top DUT (.aclk(aclk), .aclk_en(1'b1), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .init_request(init_rq),
        .init_acknowledge(init_ak), .rx_err_count(rx_cnt), .tx_err_count(tx_cnt), .wakeup_event(ev[0]),
        .overrun_event(ev[1]), .rx_full_event(ev[2]), .irq_wakeup(irq_w), .irq_error(irq_e),
        .irq_receive(irq_r), .irq(irq_any));
    // 125 MHz clock
    always #4 aclk = ~aclk;
    // xorshift source of random stimulus
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // one write, each channel released at its own handshake
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp_q = bresp;
        // enable register model: writes land only outside initialization
        if (a == OFS_ENABLE && !init_rq && !init_ak) m_en = int'(d & 32'hFF);
    endtask : wr
    // one read, data taken at the handshake edge
    task automatic rd(input logic [3:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_q = rdata;
        rsp_q = rresp;
    endtask : rd
    // wait a few cycles, then read the flag register
    task automatic settle_flags();
        repeat (3) @(posedge aclk);
        rd(OFS_FLAGS);
    endtask : settle_flags
    // verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values and an unmapped place
        rd(OFS_ENABLE);
        `CHK("enable reset", 32'h00, rd_q)
        rd(4'h8);
        `CHK("unmapped resp", RESP_SLVERR, rsp_q)
        `CHK("unmapped data", 32'h00, rd_q)
        wr(4'h8, xs());
        `CHK("unmapped bresp", RESP_SLVERR, rsp_q)
        // half init and init refuse writes; init clears event enables, keeps sensitivities
        v = xs() & 32'hFF;
        wr(OFS_ENABLE, v);
        `CHK("enable bresp", RESP_OKAY, rsp_q)
        rd(OFS_ENABLE);
        `CHK("enable write", m_en, rd_q)
        init_rq <= 1'b1;
        wr(OFS_ENABLE, ~v & 32'hFF);
        rd(OFS_ENABLE);
        `CHK("enable half init", m_en, rd_q)
        init_ak <= 1'b1;
        m_en = m_en & SENS_MASK;
        wr(OFS_ENABLE, ~v & 32'hFF);
        `CHK("init bresp", RESP_OKAY, rsp_q)
        rd(OFS_ENABLE);
        `CHK("enable in init", m_en, rd_q)
        init_ak <= 1'b0;
        @(posedge aclk);
        init_rq <= 1'b0;
        // each event with its enable on, then off
        for (int k = 0; k < 6; k++) begin
            wr(OFS_ENABLE, (k < 3) ? 32'hC3 : 32'h00);
            ev <= 3'h1 << (k % 3);
            @(posedge aclk);
            ev <= 3'h0;
            @(posedge aclk);
            @(posedge aclk);
            `CHK("irq_wakeup", k == 0, irq_w)
            `CHK("irq_error", k == 1, irq_e)
            `CHK("irq_receive", k == 2, irq_r)
            `CHK("irq", k < 3, irq_any)
            rd(OFS_FLAGS);
            `CHK("event flag", 32'h1 << fbit[k % 3], rd_q)
            wr(OFS_FLAGS, 32'hC3);
        end
        // transmitter bus-off, frozen codes, both codes normal again after exit with receive count zero
        wr(OFS_ENABLE, 32'h44);
        tx_cnt <= 9'(9'h100 + xs() % 256);
        settle_flags();
        `CHK("busoff", 32'h7C, rd_q)
        `CHK("irq_error csc", 1'b1, irq_e)
        tx_cnt <= 9'h000;
        settle_flags();
        `CHK("frozen", 32'h7C, rd_q)
        wr(OFS_FLAGS, 32'h40);
        settle_flags();
        `CHK("busoff exit", 32'h40, rd_q)
        // receiver sensitivity passive level, status-change enable off
        wr(OFS_FLAGS, 32'h40);
        wr(OFS_ENABLE, 32'h20);
        rx_cnt <= 8'(8'h61 + xs() % 31);
        settle_flags();
        `CHK("rx warn", 32'h10, rd_q)
        rx_cnt <= 8'(8'h80 + xs() % 128);
        settle_flags();
        `CHK("rx passive", 32'h60, rd_q)
        `CHK("irq_error off", 1'b0, irq_e)
        // transmitter sensitivity on every change
        wr(OFS_FLAGS, 32'hC3);
        wr(OFS_ENABLE, 32'h0C);
        tx_cnt <= 9'(9'h061 + xs() % 31);
        settle_flags();
        `CHK("tx warn", 32'h64, rd_q)
        // transmitter sensitivity at error-passive level
        wr(OFS_FLAGS, 32'hC3);
        wr(OFS_ENABLE, 32'h08);
        tx_cnt <= 9'(9'h080 + xs() % 128);
        settle_flags();
        `CHK("tx passive", 32'h68, rd_q)
        // receiver sensitivity at bus-off level, reached through transmitter bus-off
        wr(OFS_FLAGS, 32'h40);
        wr(OFS_ENABLE, 32'h10);
        tx_cnt <= 9'(9'h100 + xs() % 256);
        settle_flags();
        `CHK("rx busoff", 32'h7C, rd_q)
        results();
    end
endmodule : crie_top_tb
`default_nettype wire
